// *** drfs_hyst.sv ***
// threshold comparator with fixed release ratio
`timescale 1ns/1ps
module drfs_hyst (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // level and threshold
   input  wire logic        upd,
   input  wire logic [15:0] val,
   input  wire logic [15:0] set,
   // result
   output logic             pick
);
   import drfs_pkg::*;

   typedef struct packed {
      logic pick;
   } drfs_hyst_st_t;

   drfs_hyst_st_t s_q;
   drfs_hyst_st_t s_d;
   logic [15:0]   rel;

   assign rel  = 16'((32'(set) * RST_NUM) / RST_DEN);
   assign pick = s_q.pick;

   always_comb begin
      s_d = s_q;
      if (upd) begin
         if (val > set) begin
            s_d.pick = 1'b1;
         end else if (val < rel) begin
            s_d.pick = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge ref_clk iff ce); endclocking
   default disable iff (rst);

   a_hyst_hold: assert property (
      (s_q.pick && upd && val >= rel) |=> s_q.pick)
      else $error("pick-up released above release level");

endmodule : drfs_hyst

// *** drfs_meas_src.sv ***
// measurement chain model: magnitudes on the 5 ms strobe, raw samples
`timescale 1ns/1ps
module drfs_meas_src
   import drfs_pkg::*;
#(
   parameter int PERIOD = 50
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // levels to present
   input  wire logic [15:0]          i_lvl,
   input  wire logic [15:0]          u_lvl,
   // chain outputs
   output logic                      meas_valid,
   output drfs_pkg::drfs_meas_t      meas,
   output logic                      samp_valid,
   output logic signed [15:0]        samp
);
   int cnt_q;

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk) begin
      samp_valid <= !rst;
      // alternating halves so that max minus min equals the level rounded down to even
      samp       <= cnt_q[0] ? 16'(i_lvl >> 1) : -16'(i_lvl >> 1);
      meas_valid <= !rst && cnt_q == PERIOD - 1;
      meas       <= '{i_lvl, i_lvl, i_lvl, i_lvl, i_lvl, u_lvl, u_lvl,
                      16'sh0000, 16'sh0000};
      cnt_q      <= (rst || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
   end
endmodule : drfs_meas_src

// *** drfs_pkg.sv ***
// shared types and constants of the directional residual stage
package drfs_pkg;

   ////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_HZ     = 50_000_000;
   localparam int TS_RES_MS  = 1;
   localparam int MS_CYC_DEF = CLK_HZ / 1000 * TS_RES_MS;
   localparam int BASE_MS    = 5;
   localparam int PRE_MS     = 20;
   localparam int PRE_TAPS   = PRE_MS / BASE_MS;
   localparam int PRE_DEPTH  = 2 * PRE_TAPS;
   localparam int PRE_SHIFT  = $clog2(PRE_TAPS);

   ////////////////////////////////////////////////////////////////////////
   // sizes, ratios, limits
   localparam int NUM_STAGES = 4;
   localparam int NUM_GRP    = 8;
   localparam int RST_NUM    = 97;
   localparam int RST_DEN    = 100;
   localparam int SQ_DEN     = 100;
   localparam logic [15:0] I_NOM = 16'h03E8;
   localparam logic [15:0] U_NOM = 16'h03E8;
   localparam logic [15:0] I_SQ  = 16'(I_NOM / SQ_DEN);
   localparam logic [15:0] U_SQ  = 16'(U_NOM / SQ_DEN);
   // angles in hundredths of a degree
   localparam logic signed [17:0] ANG_HALF = 18'sh04650;
   localparam logic signed [17:0] ANG_FULL = 18'sh08CA0;
   localparam logic [31:0] MUL_IEC  = 32'h1;
   localparam logic [31:0] MUL_ANSI = 32'h2;

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] A_CFG      = 8'h00;
   localparam logic [7:0] A_SECTOR   = 8'h01;
   localparam logic [7:0] A_STATUS   = 8'h02;
   localparam logic [7:0] A_CNT_ST   = 8'h03;
   localparam logic [7:0] A_CNT_TR   = 8'h04;
   localparam logic [7:0] A_CNT_BL   = 8'h05;
   localparam logic [7:0] A_STAMP    = 8'h06;
   localparam logic [7:0] A_GRP_BASE = 8'h20;
   localparam logic [7:0] A_GRP_MASK = 8'hE0;
   localparam int GI_MSB = 4;
   localparam int GI_LSB = 2;
   localparam int GF_MSB = 1;
   localparam logic [1:0] GF_ISET = 2'h0;
   localparam logic [1:0] GF_USET = 2'h1;
   localparam logic [1:0] GF_TDLY = 2'h2;

   // output bit positions
   localparam int OUT_ST = 0;
   localparam int OUT_TR = 1;
   localparam int OUT_BL = 2;
   localparam int NUM_OUT = 3;

   ////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {IN_COARSE, IN_SENS, IN_CALC} drfs_insel_t;
   typedef enum logic [1:0] {MAG_RMS, MAG_TRMS, MAG_PP} drfs_mag_t;
   typedef enum logic [1:0] {MD_INSTANT, MD_DT, MD_IDMT} drfs_mode_t;
   typedef enum logic [1:0] {CV_IEC, CV_ANSI, CV_CUSTOM} drfs_curve_t;

   typedef struct packed {
      logic [3:0]  cust_k;
      drfs_curve_t curve;
      drfs_mode_t  mode;
      logic        u_inv;
      logic        u_calc;
      drfs_mag_t   mag;
      drfs_insel_t in_sel;
   } drfs_cfg_t;
   localparam int CFG_W = $bits(drfs_cfg_t);

   typedef struct packed {
      logic [15:0] tdly;
      logic [15:0] uset;
      logic [15:0] iset;
   } drfs_grp_t;

   typedef struct packed {
      logic signed [15:0] half;
      logic signed [15:0] center;
   } drfs_sector_t;

   typedef struct packed {
      logic [15:0]        coarse_rms;
      logic [15:0]        coarse_trms;
      logic [15:0]        sens_rms;
      logic [15:0]        sens_trms;
      logic [15:0]        calc_rms;
      logic [15:0]        u_rms;
      logic [15:0]        u_calc;
      logic signed [15:0] i_ang;
      logic signed [15:0] u_ang;
   } drfs_meas_t;

   typedef struct packed {
      logic [31:0] stamp;
      logic [2:0]  changed;
      logic [2:0]  level;
      logic [15:0] prefault;
      logic [15:0] value;
      logic [1:0]  stage;
   } drfs_event_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } drfs_bus_t;

   typedef enum logic [1:0] {TM_IDLE, TM_RUN, TM_TRIPPED} drfs_tm_t;

endpackage : drfs_pkg

// *** drfs_prefault.sv ***
// pre-fault average over a window that lags the present
`timescale 1ns/1ps
module drfs_prefault (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // magnitude stream
   input  wire logic        upd,
   input  wire logic [15:0] val,
   // average
   output logic [15:0]      avg
);
   import drfs_pkg::*;

   typedef struct packed {
      logic [PRE_DEPTH-1:0][15:0] hist;
      logic [15:0]                avg;
   } drfs_pre_st_t;

   drfs_pre_st_t s_q;
   drfs_pre_st_t s_d;

   assign avg = s_q.avg;

   always_comb begin
      logic [17:0] sum;
      sum = '0;
      s_d = s_q;
      if (upd) begin
         s_d.hist = {s_q.hist[PRE_DEPTH-2:0], val};
         // oldest taps only: window ends one window before now
         for (int i = PRE_TAPS; i < PRE_DEPTH; i++) begin
            sum = sum + 18'(s_d.hist[i]);
         end
         s_d.avg = 16'(sum >> PRE_SHIFT);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

endmodule : drfs_prefault

// *** drfs_stage.sv ***
// directional residual fault stage: select, compare, delay, report
`timescale 1ns/1ps
module drfs_stage #(
   parameter logic [1:0] STAGE_ID  = 2'h0,
   parameter int         MS_CYCLES = drfs_pkg::MS_CYC_DEF
) (
   // clock and reset
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                ce,
   // register port
   input  wire drfs_pkg::drfs_bus_t bus,
   output logic [31:0]              rdata,
   // measurement chain
   input  wire logic                meas_valid,
   input  wire drfs_pkg::drfs_meas_t meas,
   input  wire logic                samp_valid,
   input  wire logic signed [15:0]  coarse_samp,
   input  wire logic signed [15:0]  sens_samp,
   // control
   input  wire logic                block_in,
   input  wire logic [2:0]          grp_sel,
   // outputs
   output logic                     start,
   output logic                     trip,
   output logic                     blocked,
   // event
   output logic                     ev_valid,
   output drfs_pkg::drfs_event_t    ev
);
   import drfs_pkg::*;

   typedef struct packed {
      drfs_cfg_t                    cfg;
      drfs_sector_t                 sector;
      drfs_grp_t [NUM_GRP-1:0]      grp;
      logic [15:0]                  ms_cnt;
      logic [31:0]                  stamp;
      logic signed [15:0]           pk_max;
      logic signed [15:0]           pk_min;
      logic [15:0]                  i_mag;
      logic [15:0]                  u_mag;
      logic                         ang_ok;
      logic                         dir_ok;
      drfs_tm_t                     tm;
      logic [31:0]                  acc;
      logic [NUM_OUT-1:0]           outs;
      logic [NUM_OUT-1:0][15:0]     cnt;
      logic                         ev_valid;
      drfs_event_t                  ev;
      logic [31:0]                  rdata;
   } drfs_stage_st_t;

   drfs_stage_st_t     s_q;
   drfs_stage_st_t     s_d;
   logic [15:0]        sel_i;
   logic [15:0]        sel_u;
   logic [15:0]        pp_now;
   logic               pick_i;
   logic               pick_u;
   logic [15:0]        pre_avg;
   logic               tick;
   drfs_grp_t          g;

   ////////////////////////////////////////////////////////////////////////
   // input selection from stored settings; settings group indexed by the live grp_sel input
   assign pp_now = 16'(s_q.pk_max - s_q.pk_min);
   assign g      = s_q.grp[grp_sel];
   assign tick   = s_q.ms_cnt == 16'(MS_CYCLES - 1);

   always_comb begin
      sel_i = meas.coarse_rms;
      case (s_q.cfg.in_sel)
         IN_COARSE: begin
            case (s_q.cfg.mag)
               MAG_TRMS: sel_i = meas.coarse_trms;
               MAG_PP:   sel_i = pp_now;
               default:  sel_i = meas.coarse_rms;
            endcase
         end
         IN_SENS: begin
            case (s_q.cfg.mag)
               MAG_TRMS: sel_i = meas.sens_trms;
               MAG_PP:   sel_i = pp_now;
               default:  sel_i = meas.sens_rms;
            endcase
         end
         IN_CALC: sel_i = meas.calc_rms;
         default: sel_i = meas.coarse_rms;
      endcase
      sel_u = s_q.cfg.u_calc ? meas.u_calc : meas.u_rms;
   end

   ////////////////////////////////////////////////////////////////////////
   // magnitude comparators and pre-fault history
   drfs_hyst u_hyst_i (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .upd     (meas_valid),
      .val     (sel_i),
      .set     (g.iset),
      .pick    (pick_i)
   );

   drfs_hyst u_hyst_u (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .upd     (meas_valid),
      .val     (sel_u),
      .set     (g.uset),
      .pick    (pick_u)
   );

   drfs_prefault u_pre (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .upd     (meas_valid),
      .val     (sel_i),
      .avg     (pre_avg)
   );

   ////////////////////////////////////////////////////////////////////////
   // main update
   always_comb begin
      logic signed [15:0]  samp;
      logic signed [17:0]  d;
      logic signed [17:0]  ad;
      logic                ang_ok;
      logic                st;
      logic                tr;
      logic                bl;
      logic [31:0]         excess;
      logic [31:0]         mult;
      logic [31:0]         goal;
      logic [31:0]         acc_n;
      logic [NUM_OUT-1:0]  outs;
      logic [NUM_OUT-1:0]  chg;
      samp   = '0;
      d      = '0;
      ad     = '0;
      ang_ok = 1'b0;
      st     = 1'b0;
      tr     = 1'b0;
      bl     = 1'b0;
      excess = '0;
      mult   = '0;
      goal   = '0;
      acc_n  = '0;
      outs   = '0;
      chg    = '0;
      s_d          = s_q;
      s_d.ev_valid = 1'b0;
      s_d.rdata    = '0;

      // millisecond stamp base
      s_d.ms_cnt = tick ? '0 : s_q.ms_cnt + 16'h0001;
      if (tick) begin
         s_d.stamp = s_q.stamp + 32'h0000_0001;
      end

      // raw peak tracking between measurement strobes
      samp = (s_q.cfg.in_sel == IN_SENS) ? sens_samp : coarse_samp;
      if (meas_valid) begin
         s_d.pk_max = samp;
         s_d.pk_min = samp;
      end else if (samp_valid) begin
         if (samp > s_q.pk_max) begin
            s_d.pk_max = samp;
         end
         if (samp < s_q.pk_min) begin
            s_d.pk_min = samp;
         end
      end

      // angle against neutral voltage, refreshed every strobe
      d = 18'(meas.i_ang) - 18'(meas.u_ang);
      if (s_q.cfg.u_inv) begin
         d = d + ANG_HALF;
      end
      d = d - 18'(s_q.sector.center);
      for (int k = 0; k < 2; k++) begin
         if (d > ANG_HALF) begin
            d = d - ANG_FULL;
         end else if (d < -ANG_HALF) begin
            d = d + ANG_FULL;
         end
      end
      ad = (d < 0) ? -d : d;
      ang_ok = (sel_i > I_SQ) && (sel_u > U_SQ);
      if (meas_valid) begin
         s_d.i_mag  = sel_i;
         s_d.u_mag  = sel_u;
         s_d.ang_ok = ang_ok;
         s_d.dir_ok = ang_ok && (ad <= 18'(s_q.sector.half));
      end

      // compare, angle, block
      bl = pick_i && block_in;
      st = pick_i && pick_u && s_q.ang_ok && s_q.dir_ok
           && !block_in;

      // time characteristic
      excess = (s_q.i_mag > g.iset) ? 32'(s_q.i_mag - g.iset) : '0;
      case (s_q.cfg.curve)
         CV_ANSI:   mult = MUL_ANSI;
         CV_CUSTOM: mult = 32'(s_q.cfg.cust_k);
         default:   mult = MUL_IEC;
      endcase
      if (s_q.cfg.mode == MD_IDMT) begin
         goal  = 32'(g.tdly) * 32'(g.iset);
         acc_n = s_q.acc + 32'(excess * mult);
      end else begin
         goal  = 32'(g.tdly);
         acc_n = s_q.acc + 32'h0000_0001;
      end
      case (s_q.tm)
         TM_IDLE: begin
            s_d.acc = '0;
            if (st) begin
               s_d.tm = (s_q.cfg.mode == MD_INSTANT) ? TM_TRIPPED : TM_RUN;
            end
         end
         TM_RUN: begin
            if (!st) begin
               s_d.tm  = TM_IDLE;
               s_d.acc = '0;
            end else if (tick) begin
               s_d.acc = acc_n;
               if (acc_n >= goal) begin
                  s_d.tm = TM_TRIPPED;
               end
            end
         end
         TM_TRIPPED: begin
            if (!st) begin
               s_d.tm  = TM_IDLE;
               s_d.acc = '0;
            end
         end
         default: begin
            s_d.tm  = TM_IDLE;
            s_d.acc = '0;
         end
      endcase
      // instant: trip rises with start in the same cycle
      tr = st && ((s_q.tm == TM_TRIPPED)
                  || (s_q.cfg.mode == MD_INSTANT));

      // outputs, events, counters
      outs = '0;
      outs[OUT_ST] = st;
      outs[OUT_TR] = tr;
      outs[OUT_BL] = bl;
      chg = outs ^ s_q.outs;
      s_d.outs = outs;
      if (chg != '0) begin
         s_d.ev_valid    = 1'b1;
         s_d.ev.stamp    = s_q.stamp;
         s_d.ev.changed  = chg;
         s_d.ev.level    = outs;
         s_d.ev.prefault = pre_avg;
         s_d.ev.value    = s_q.i_mag;
         s_d.ev.stage    = STAGE_ID;
      end
      for (int k = 0; k < NUM_OUT; k++) begin
         if (outs[k] && !s_q.outs[k]) begin
            s_d.cnt[k] = s_q.cnt[k] + 16'h0001;
         end
      end

      // register port
      if (bus.wr) begin
         if (bus.addr == A_CFG) begin
            s_d.cfg = drfs_cfg_t'(bus.wdata[CFG_W-1:0]);
         end else if (bus.addr == A_SECTOR) begin
            s_d.sector = drfs_sector_t'(bus.wdata);
         end else if ((bus.addr & A_GRP_MASK) == A_GRP_BASE) begin
            case (bus.addr[GF_MSB:0])
               GF_ISET: s_d.grp[bus.addr[GI_MSB:GI_LSB]].iset =
                           bus.wdata[15:0];
               GF_USET: s_d.grp[bus.addr[GI_MSB:GI_LSB]].uset =
                           bus.wdata[15:0];
               GF_TDLY: s_d.grp[bus.addr[GI_MSB:GI_LSB]].tdly =
                           bus.wdata[15:0];
               default: s_d.grp = s_q.grp;
            endcase
         end
      end
      if (bus.rd) begin
         case (bus.addr)
            A_CFG:    s_d.rdata = 32'(s_q.cfg);
            A_SECTOR: s_d.rdata = 32'(s_q.sector);
            A_STATUS: s_d.rdata = 32'({grp_sel, s_q.tm, s_q.dir_ok,
                                       s_q.ang_ok, s_q.outs});
            A_CNT_ST: s_d.rdata = 32'(s_q.cnt[OUT_ST]);
            A_CNT_TR: s_d.rdata = 32'(s_q.cnt[OUT_TR]);
            A_CNT_BL: s_d.rdata = 32'(s_q.cnt[OUT_BL]);
            A_STAMP:  s_d.rdata = s_q.stamp;
            default: begin
               if ((bus.addr & A_GRP_MASK) == A_GRP_BASE) begin
                  case (bus.addr[GF_MSB:0])
                     GF_ISET: s_d.rdata =
                        32'(s_q.grp[bus.addr[GI_MSB:GI_LSB]].iset);
                     GF_USET: s_d.rdata =
                        32'(s_q.grp[bus.addr[GI_MSB:GI_LSB]].uset);
                     GF_TDLY: s_d.rdata =
                        32'(s_q.grp[bus.addr[GI_MSB:GI_LSB]].tdly);
                     default: s_d.rdata = '0;
                  endcase
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign start    = s_q.outs[OUT_ST];
   assign trip     = s_q.outs[OUT_TR];
   assign blocked  = s_q.outs[OUT_BL];
   assign ev_valid = s_q.ev_valid;
   assign ev       = s_q.ev;
   assign rdata    = s_q.rdata;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk iff ce); endclocking
   default disable iff (rst);

   a_instant_trip: assert property (
      (start && $past(s_q.cfg.mode) == MD_INSTANT) |-> trip)
      else $error("instant start without trip");

   a_trip_start: assert property (trip |-> start)
      else $error("trip without start");

   a_block_excl: assert property (!(blocked && start))
      else $error("start and blocked together");

   a_event_change: assert property (
      ev_valid == (s_q.outs != $past(s_q.outs)))
      else $error("event does not match output change");

   a_event_level: assert property (
      ev_valid |-> (ev.level == s_q.outs
                    && ev.stamp == $past(s_q.stamp)))
      else $error("event level or stamp wrong");

   a_count_start: assert property (
      $rose(start) |-> s_q.cnt[OUT_ST] == $past(s_q.cnt[OUT_ST]) + 16'h0001)
      else $error("start counter missed");

   a_squelch_gate: assert property (
      s_q.ang_ok |-> (s_q.i_mag > I_SQ && s_q.u_mag > U_SQ))
      else $error("angle valid below squelch");

   a_timer_hold: assert property (
      (block_in || !s_q.ang_ok) |=> s_q.acc <= $past(s_q.acc))
      else $error("delay advanced while blocked or squelched");

   a_stamp_step: assert property (
      tick |=> s_q.stamp == $past(s_q.stamp) + 32'h0000_0001)
      else $error("stamp did not step on millisecond");

   a_read_once: assert property (!$past(bus.rd) |-> rdata == '0)
      else $error("read data outside its cycle");

endmodule : drfs_stage

// *** test_drfs_stage.sv ***
// self-checking bench for the directional residual stage
`timescale 1ns/1ps
module test_drfs_stage;
   import drfs_pkg::*;
   localparam int MS = 10;
   logic               ref_clk = 1'b0;
   logic               rst = 1'b1;
   logic               ce = 1'b1;
   drfs_bus_t          bus = '0;
   logic [31:0]        rdata;
   logic               meas_valid;
   logic               samp_valid;
   drfs_meas_t         meas;
   logic signed [15:0] samp;
   logic [15:0]        i_lvl = '0;
   logic [15:0]        u_lvl = '0;
   logic               block_in = 1'b0;
   logic [2:0]         grp_sel = 3'h0;
   logic               start;
   logic               trip;
   logic               blocked;
   logic               ev_valid;
   drfs_event_t        ev;
   logic [31:0]        rd_val;
   logic [31:0]        stamp0;
   logic [31:0]        cfgs [4] = '{32'h40, 32'h485, 32'h592, 32'h688};
   int                 num_errors = 0;
   int                 total_checks = 0;

   initial forever #10 ref_clk = ~ref_clk;

   drfs_meas_src #(.PERIOD(5 * MS)) drfs_meas_src_i (
      .ref_clk(ref_clk), .rst(rst), .i_lvl(i_lvl), .u_lvl(u_lvl),
      .meas_valid(meas_valid), .meas(meas), .samp_valid(samp_valid),
      .samp(samp));
   drfs_stage #(.STAGE_ID(2'h2), .MS_CYCLES(MS)) drfs_stage_i (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata),
      .meas_valid(meas_valid), .meas(meas), .samp_valid(samp_valid),
      .coarse_samp(samp), .sens_samp(samp), .block_in(block_in),
      .grp_sel(grp_sel), .start(start), .trip(trip), .blocked(blocked),
      .ev_valid(ev_valid), .ev(ev));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk) bus <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge ref_clk) bus <= '0;
      #1 rd_val = rdata;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_val, exp);
   endtask : rdchk
   task automatic lv(input logic [15:0] i, input logic [15:0] u);
      @(posedge ref_clk) i_lvl <= i;
      u_lvl <= u;
   endtask : lv
   // wait for n measurement strobes, then let the outputs settle
   task automatic strobes(input int n);
      // new levels must reach the chain, both sample halves included
      repeat (3) @(posedge ref_clk);
      repeat (n) begin
         @(posedge ref_clk);
         while (meas_valid !== 1'b1) @(posedge ref_clk);
      end
      repeat (3) @(posedge ref_clk);
      #1;
   endtask : strobes
   task automatic outs(input logic [2:0] e);
      chk(32'({blocked, trip, start}), 32'(e));
   endtask : outs
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (400 * MS) @(posedge ref_clk);
      num_errors++;
      $display("watchdog expired at %0t", $time);
      end_sim();
   end

   initial begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(A_CFG, 32'h0);
      rdchk(A_CNT_TR, 32'h0);
      wr(8'h10, 32'hFFFF_FFFF);
      rdchk(8'h10, 32'h0);
      rd(A_STAMP);
      stamp0 = rd_val;
      // 20 frozen cycles: only 80 running cycles, so 8 ms
      @(posedge ref_clk) ce <= 1'b0;
      repeat (20) @(posedge ref_clk);
      ce <= 1'b1;
      repeat (10 * MS - 23) @(posedge ref_clk);
      rd(A_STAMP);
      chk(rd_val - stamp0, 32'h8);
      $display("test reset_stamp done");
      wr(A_SECTOR, 32'h2328_0000);
      rdchk(A_SECTOR, 32'h2328_0000);
      wr(A_GRP_BASE, 32'h64);
      wr(A_GRP_BASE + 8'h1, 32'h32);
      lv(16'hC8, 16'h64);
      strobes(1);
      outs(3'h3);
      chk(32'({ev.value, ev.changed, ev.level, ev.stage}), 32'hC86E);
      rdchk(A_CNT_ST, 32'h1);
      rdchk(A_CNT_TR, 32'h1);
      lv(16'h62, 16'h64);
      strobes(1);
      outs(3'h3);
      lv(16'h5A, 16'h64);
      strobes(1);
      outs(3'h0);
      chk(32'({ev.value, ev.changed, ev.level, ev.stage}), 32'h5A62);
      $display("test instant_hyst done");
      wr(A_GRP_BASE + 8'h1, 32'h0);
      lv(16'hC8, 16'h5);
      strobes(2);
      outs(3'h0);
      lv(16'hC8, 16'h64);
      strobes(1);
      outs(3'h3);
      @(posedge ref_clk) block_in <= 1'b1;
      strobes(1);
      outs(3'h4);
      rdchk(A_CNT_BL, 32'h1);
      rdchk(A_STATUS, 32'h1C);
      @(posedge ref_clk) block_in <= 1'b0;
      strobes(1);
      outs(3'h3);
      lv(16'h0, 16'h64);
      strobes(1);
      outs(3'h0);
      $display("test squelch_block done");
      wr(A_GRP_BASE + 8'h14, 32'h12C);
      wr(A_GRP_BASE + 8'h15, 32'h32);
      @(posedge ref_clk) grp_sel <= 3'h5;
      lv(16'hC8, 16'h64);
      strobes(1);
      outs(3'h0);
      @(posedge ref_clk) grp_sel <= 3'h0;
      strobes(1);
      outs(3'h3);
      wr(A_CFG, 32'h20);
      strobes(2);
      outs(3'h0);
      lv(16'h0, 16'h64);
      strobes(2);
      outs(3'h0);
      $display("test group_invert done");
      wr(A_GRP_BASE + 8'h2, 32'h3);
      for (int k = 0; k < 4; k++) begin
         wr(A_CFG, cfgs[k]);
         lv(16'hC8, 16'h64);
         strobes(1);
         outs(3'h1);
         repeat (5 * MS) @(posedge ref_clk);
         #1;
         outs(3'h3);
         lv(16'h0, 16'h64);
         strobes(2);
         outs(3'h0);
      end
      $display("test delay_modes done");
      end_sim();
   end
endmodule : test_drfs_stage
